// ==== rtl/qnvdc_defs.vh ====
`ifndef QNVDC_DEFS_VH
`define QNVDC_DEFS_VH

// core clock period in ns
`define QNVDC_CLK_NS 20
// erase/write cycle length, longest figure, in us
`define QNVDC_BUSY_US 5000
`define QNVDC_BUSY_CYC ((`QNVDC_BUSY_US * 1000) / `QNVDC_CLK_NS)
// least deselect time in ns, and in core cycles (rounded up)
`define QNVDC_DESEL_NS 150
`define QNVDC_DESEL_CYC ((`QNVDC_DESEL_NS + `QNVDC_CLK_NS - 1) / `QNVDC_CLK_NS)
// frame: start bit + 2 address bits + 8 data bits
`define QNVDC_FRAME_BITS 11
`define QNVDC_ADDR_POS 1
`define QNVDC_DATA_POS 3
// gap after the last data bit before the next start bit, in link clocks
`define QNVDC_GAP_CLKS 2
// factory nonvolatile contents
`define QNVDC_NV_RESET 8'h80

`endif

// ==== rtl/qnvdc_nv_store.v ====
`timescale 1ns/1ns
`default_nettype none
`include "qnvdc_defs.vh"

// nonvolatile copy of the four settings with an erase/write timer
module qnvdc_nv_store #(
    parameter BUSY_CYC = `QNVDC_BUSY_CYC
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    // write request
    input wire wr_i,
    input wire [1:0] wr_chan_i,
    input wire [7:0] wr_data_i,
    // stored contents
    output wire [31:0] nv_all_o,
    output reg busy_o
);
    reg [7:0] nv_q [0:3];
    reg [31:0] cnt_q;
    integer i;

    // array stands in for the cells; contents survive the reset pulse
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
            cnt_q <= 32'h0;
        end else if (clk_en_i) begin
            if (wr_i && !busy_o) begin
                busy_o <= 1'b1;
                cnt_q <= BUSY_CYC - 1;
            end else if (busy_o) begin
                if (cnt_q == 32'h0) begin
                    busy_o <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 32'h1;
                end
            end
        end
    end

    initial begin
        for (i = 0; i < 4; i = i + 1) begin
            nv_q[i] = `QNVDC_NV_RESET;
        end
    end

    always @(posedge core_clk_i) begin
        if (clk_en_i && wr_i && !busy_o) begin
            nv_q[wr_chan_i] <= wr_data_i;
        end
    end

    assign nv_all_o = {nv_q[3], nv_q[2], nv_q[1], nv_q[0]};
endmodule // qnvdc_nv_store

`default_nettype wire

// ==== rtl/qnvdc_top.v ====
`timescale 1ns/1ns
`default_nettype none
`include "qnvdc_defs.vh"

// Contract
// - four independent 8-bit settings, one per output channel.
// - settings kept nonvolatile and reloaded at power-up without link clock.
// - trial loads change the live value only, never the stored copy.
// - read-back then restore leaves the channel output unchanged.
// - serial traffic accepted only while chip select is high.
// - data output driven only while selected, otherwise released.
// - busy suppressed when supply is too low to write.
// - busy from falling clock after store strobe high until write done; strobe counts only in a frame, busy from the fall after its last data bit.
// - deselect reloads all live settings and releases data output.
// - while writing, serial input ignored and no data driven.
// - old register contents shift out while new bits shift in.
module qnvdc_top #(
    parameter BUSY_CYC = `QNVDC_BUSY_CYC
) (
    // clock and reset
    input wire core_clk_i,
    input wire rst_n_i,
    input wire clk_en_i,
    // serial link pins
    input wire link_clk_i,
    input wire chip_sel_i,
    input wire serial_in_i,
    input wire store_strobe_i,
    input wire supply_ok_i,
    output reg serial_out_o,
    output reg serial_out_oe_o,
    output reg nv_write_idle_flag_o,
    // live settings
    output reg [7:0] level0_o,
    output reg [7:0] level1_o,
    output reg [7:0] level2_o,
    output reg [7:0] level3_o
);
    localparam [2:0] ST_LOAD = 3'b001;
    localparam [2:0] ST_RUN = 3'b010;
    localparam [2:0] ST_STORE_STROBE = 3'b100;
    localparam [7:0] DESEL_CYC = `QNVDC_DESEL_CYC;

    reg rst_m_q, rst_s_q;
    wire rst_n = rst_s_q;
    // three-stage synchronisers: [0] meta, [1] and [2] compared
    reg [2:0] clk_sy_q, cs_sy_q, di_sy_q, pg_sy_q, ok_sy_q;
    reg clk_st_q, cs_st_q, di_st_q, pg_st_q, ok_st_q;
    reg [2:0] state_q;
    reg [3:0] bit_q;
    reg [1:0] chan_q;
    reg [7:0] live_q [0:3];
    reg [7:0] desel_q;
    reg pg_seen_q, wr_q, gap_q;
    reg [1:0] gap_cnt_q;
    wire [31:0] nv_all;
    wire nv_busy;
    integer k;

    function filt;
        input [2:0] s;
        input st;
        begin
            filt = (s[1] == s[2]) ? s[2] : st;
        end
    endfunction

    wire clk_f = filt(clk_sy_q, clk_st_q);
    wire rise = clk_f & ~clk_st_q;
    wire fall = ~clk_f & clk_st_q;
    wire cs_f = filt(cs_sy_q, cs_st_q);
    wire ok_f = filt(ok_sy_q, ok_st_q);
    wire pg_f = filt(pg_sy_q, pg_st_q);
    wire di_f = filt(di_sy_q, di_st_q);

    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            clk_sy_q <= 3'h0;
            cs_sy_q <= 3'h0;
            di_sy_q <= 3'h0;
            pg_sy_q <= 3'h0;
            ok_sy_q <= 3'h0;
            clk_st_q <= 1'b0;
            cs_st_q <= 1'b0;
            di_st_q <= 1'b0;
            pg_st_q <= 1'b0;
            ok_st_q <= 1'b0;
        end else if (clk_en_i) begin
            clk_sy_q <= {clk_sy_q[1:0], link_clk_i};
            cs_sy_q <= {cs_sy_q[1:0], chip_sel_i};
            di_sy_q <= {di_sy_q[1:0], serial_in_i};
            pg_sy_q <= {pg_sy_q[1:0], store_strobe_i};
            ok_sy_q <= {ok_sy_q[1:0], supply_ok_i};
            clk_st_q <= clk_f;
            cs_st_q <= cs_f;
            di_st_q <= di_f;
            pg_st_q <= pg_f;
            ok_st_q <= ok_f;
        end
    end

    always @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_LOAD;
            bit_q <= 4'h0;
            chan_q <= 2'h0;
            desel_q <= 8'h0;
            pg_seen_q <= 1'b0;
            wr_q <= 1'b0;
            gap_q <= 1'b0;
            gap_cnt_q <= 2'h0;
            serial_out_o <= 1'b0;
            serial_out_oe_o <= 1'b0;
            nv_write_idle_flag_o <= 1'b1;
            level0_o <= 8'h0;
            level1_o <= 8'h0;
            level2_o <= 8'h0;
            level3_o <= 8'h0;
            for (k = 0; k < 4; k = k + 1) begin
                live_q[k] <= 8'h0;
            end
        end else if (clk_en_i) begin
            wr_q <= 1'b0;
            // supply monitor gates busy off when too low
            nv_write_idle_flag_o <= ~(nv_busy & ok_f);
            // deselect counted so a new select is taken only after the least deselect time
            if (!cs_f) begin
                if (desel_q != DESEL_CYC) begin
                    desel_q <= desel_q + 8'h1;
                end
            end else begin
                desel_q <= 8'h0;
            end
            case (state_q)
                ST_LOAD: begin
                    // reload from storage, no link clock needed
                    for (k = 0; k < 4; k = k + 1) begin
                        live_q[k] <= nv_all[8*k +: 8];
                    end
                    bit_q <= 4'h0;
                    gap_q <= 1'b0;
                    pg_seen_q <= 1'b0;
                    serial_out_oe_o <= 1'b0;
                    if (cs_f && desel_q == DESEL_CYC) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    serial_out_oe_o <= 1'b1;
                    if (!cs_f) begin
                        state_q <= ST_LOAD;
                    end else begin
                        if (pg_f && bit_q != 4'h0) begin
                            pg_seen_q <= 1'b1;
                        end
                        if (gap_q) begin
                            if (rise) begin
                                gap_cnt_q <= gap_cnt_q + 2'h1;
                                if (gap_cnt_q == `QNVDC_GAP_CLKS - 1) begin
                                    gap_q <= 1'b0;
                                end
                            end
                        end else if (rise) begin
                            if (bit_q == 4'h0) begin
                                if (di_f) begin
                                    bit_q <= 4'h1;
                                end
                            end else if (bit_q < `QNVDC_DATA_POS) begin
                                chan_q[bit_q - `QNVDC_ADDR_POS] <= di_f;
                                bit_q <= bit_q + 4'h1;
                            end else begin
                                // shift right: old lsb leaves first
                                serial_out_o <= live_q[chan_q][0];
                                live_q[chan_q] <= {di_f, live_q[chan_q][7:1]};
                                if (bit_q == `QNVDC_FRAME_BITS - 1) begin
                                    bit_q <= 4'h0;
                                    gap_q <= 1'b1;
                                    gap_cnt_q <= 2'h0;
                                end else begin
                                    bit_q <= bit_q + 4'h1;
                                end
                            end
                        end
                        if (gap_q && pg_seen_q && fall) begin
                            wr_q <= 1'b1;
                            pg_seen_q <= 1'b0;
                            state_q <= ST_STORE_STROBE;
                            serial_out_oe_o <= 1'b0;
                        end
                    end
                end
                ST_STORE_STROBE: begin
                    serial_out_oe_o <= 1'b0;
                    if (!wr_q && !nv_busy) begin
                        state_q <= cs_f ? ST_RUN : ST_LOAD;
                        bit_q <= 4'h0;
                        gap_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_LOAD;
                end
            endcase
            level0_o <= live_q[0];
            level1_o <= live_q[1];
            level2_o <= live_q[2];
            level3_o <= live_q[3];
        end
    end

    qnvdc_nv_store #(
        .BUSY_CYC(BUSY_CYC)
    ) u_nv (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n),
        .clk_en_i(clk_en_i),
        .wr_i(wr_q & ok_f),
        .wr_chan_i(chan_q),
        .wr_data_i(live_q[chan_q]),
        .nv_all_o(nv_all),
        .busy_o(nv_busy)
    );
endmodule // qnvdc_top

`default_nettype wire

// ==== sim/qnvdc_top_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
module qnvdc_top_sva #(
    parameter int BUSY_CYC = 20
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // link pins
    input wire logic chip_sel_i,
    input wire logic store_strobe_i,
    input wire logic supply_ok_i,
    input wire logic serial_out_oe_o,
    input wire logic nv_write_idle_flag_o,
    // live settings
    input wire logic [7:0] level0_o,
    input wire logic [7:0] level1_o,
    input wire logic [7:0] level2_o,
    input wire logic [7:0] level3_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic [31:0] lv = {level3_o, level2_o, level1_o, level0_o};
    int busy_q;
    // length of the current low stretch of the idle flag
    always @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) busy_q <= 0;
        else busy_q <= nv_write_idle_flag_o ? 0 : busy_q + 1;
    end
    property p_oe_unsel;
        !chip_sel_i [*8] |-> !serial_out_oe_o;
    endproperty
    a_oe_unsel: assert property (p_oe_unsel) else $error("oe while unselected");
    property p_busy_oe;
        !nv_write_idle_flag_o [*2] |-> !serial_out_oe_o;
    endproperty
    a_busy_oe: assert property (p_busy_oe) else $error("oe while busy");
    property p_busy_hold;
        !nv_write_idle_flag_o [*2] |-> $stable(lv);
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("level moved while busy");
    property p_low_supply;
        !supply_ok_i [*4] |-> nv_write_idle_flag_o;
    endproperty
    a_low_supply: assert property (p_low_supply) else $error("busy on low supply");
    property p_busy_cause;
        $fell(nv_write_idle_flag_o) |-> store_strobe_i && supply_ok_i;
    endproperty
    a_busy_cause: assert property (p_busy_cause) else $error("busy without strobe");
    // one cycle of slack either side for the flag register
    property p_busy_len;
        $rose(nv_write_idle_flag_o) |-> busy_q >= BUSY_CYC - 1 && busy_q <= BUSY_CYC + 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_busy_max;
        busy_q <= BUSY_CYC + 1;
    endproperty
    a_busy_max: assert property (p_busy_max) else $error("busy too long");
    property p_unsel_hold;
        !chip_sel_i [*8] ##1 !chip_sel_i [*8] |-> $stable(lv);
    endproperty
    a_unsel_hold: assert property (p_unsel_hold) else $error("level moved unselected");
endmodule // qnvdc_top_sva
bind qnvdc_top qnvdc_top_sva #(.BUSY_CYC(BUSY_CYC)) qnvdc_top_sva_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .chip_sel_i(chip_sel_i), .store_strobe_i(store_strobe_i), .supply_ok_i(supply_ok_i),
    .serial_out_oe_o(serial_out_oe_o), .nv_write_idle_flag_o(nv_write_idle_flag_o), .level0_o(level0_o),
    .level1_o(level1_o), .level2_o(level2_o), .level3_o(level3_o));
`default_nettype wire

// ==== sim/qnvdc_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module qnvdc_host (
    // clock
    input wire logic core_clk_i,
    // link pins
    output logic link_clk_o,
    output logic chip_sel_o,
    output logic serial_in_o,
    output logic store_strobe_o,
    input wire logic serial_out_i,
    input wire logic serial_out_oe_i
);
    initial begin
        link_clk_o = 1'b0;
        chip_sel_o = 1'b0;
        serial_in_o = 1'b0;
        store_strobe_o = 1'b0;
    end
    // 26 cycles a phase keeps high time above its floor
    task automatic pulse(output logic q);
        repeat (26) @(posedge core_clk_i);
        link_clk_o <= 1'b1;
        repeat (24) @(posedge core_clk_i);
        // released line has no pull, so it reads as the inverse
        q = serial_out_oe_i ? serial_out_i : ~serial_out_i;
        repeat (2) @(posedge core_clk_i);
        link_clk_o <= 1'b0;
    endtask
    task automatic frame(input logic sel, input logic [1:0] ch, input logic [7:0] d, input logic st,
        output logic [7:0] rd);
        logic [10:0] bits;
        logic q;
        bits = {d, ch, 1'b1};
        chip_sel_o <= sel;
        for (int i = 0; i < 11; i++) begin
            serial_in_o <= bits[i];
            if (i == 1) store_strobe_o <= st;
            pulse(q);
            if (i > 2) rd[i-3] = q;
        end
        // idle data line does not keep the last bit
        serial_in_o <= ~bits[10];
        pulse(q);
        pulse(q);
    endtask
    task automatic deselect();
        chip_sel_o <= 1'b0;
        store_strobe_o <= 1'b0;
        repeat (12) @(posedge core_clk_i);
    endtask
endmodule // qnvdc_host
`default_nettype wire

// ==== sim/qnvdc_top_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module qnvdc_top_tb_top;
    logic core_clk_i, rst_n_i, clk_en_i, link_clk_i, chip_sel_i, serial_in_i, store_strobe_i, supply_ok_i;
    wire logic serial_out_o, serial_out_oe_o, nv_write_idle_flag_o;
    wire logic [7:0] level0_o, level1_o, level2_o, level3_o;
    wire logic [31:0] lv = {level3_o, level2_o, level1_o, level0_o};
    int n_fail, samples_checked, cyc, busy_n;
    logic [7:0] rd;
    logic [7:0] kept [4];
    qnvdc_top #(.BUSY_CYC(20)) qnvdc_top_i (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
        .link_clk_i(link_clk_i), .chip_sel_i(chip_sel_i), .serial_in_i(serial_in_i), .store_strobe_i(store_strobe_i),
        .supply_ok_i(supply_ok_i), .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o),
        .nv_write_idle_flag_o(nv_write_idle_flag_o), .level0_o(level0_o), .level1_o(level1_o), .level2_o(level2_o),
        .level3_o(level3_o));
    qnvdc_host qnvdc_host_i (.core_clk_i(core_clk_i), .link_clk_o(link_clk_i), .chip_sel_o(chip_sel_i),
        .serial_in_o(serial_in_i), .store_strobe_o(store_strobe_i), .serial_out_i(serial_out_o),
        .serial_out_oe_i(serial_out_oe_o));
    initial begin
        core_clk_i = 1'b0;
        forever #10 core_clk_i = ~core_clk_i;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (!nv_write_idle_flag_o) busy_n <= busy_n + 1;
        if (cyc == 40000) begin
            n_fail++;
            close_out();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic t_power();
        for (int c = 0; c < 4; c++) check(lv[c*8 +: 8], 8'h80);
        check(nv_write_idle_flag_o, 1'b1);
        check(serial_out_oe_o, 1'b0);
    endtask
    task automatic t_trial();
        qnvdc_host_i.frame(1'b1, 2'd2, 8'h5a, 1'b0, rd);
        check(rd, 8'h80);
        check(lv, 32'h805a8080);
        check(serial_out_oe_o, 1'b1);
        qnvdc_host_i.deselect();
        check(lv, 32'h80808080);
        check(serial_out_oe_o, 1'b0);
    endtask
    // store each channel, then read it back and let deselect restore it
    task automatic t_store();
        int b0;
        for (int c = 0; c < 4; c++) begin
            kept[c] = 8'h17 << c;
            b0 = busy_n;
            qnvdc_host_i.frame(1'b1, 2'(c), kept[c], 1'b1, rd);
            qnvdc_host_i.deselect();
            check(busy_n > b0, 1'b1);
            check(lv[c*8 +: 8], kept[c]);
            qnvdc_host_i.frame(1'b1, 2'(c), 8'h00, 1'b0, rd);
            check(rd, kept[c]);
            qnvdc_host_i.deselect();
            check(lv[c*8 +: 8], kept[c]);
        end
    endtask
    task automatic t_low();
        int b0;
        b0 = busy_n;
        supply_ok_i <= 1'b0;
        qnvdc_host_i.frame(1'b1, 2'd1, 8'hc3, 1'b1, rd);
        qnvdc_host_i.deselect();
        check(busy_n == b0, 1'b1);
        check(lv[15:8], kept[1]);
        supply_ok_i <= 1'b1;
    endtask
    task automatic t_unsel();
        qnvdc_host_i.frame(1'b0, 2'd3, 8'h00, 1'b0, rd);
        check(lv, {kept[3], kept[2], kept[1], kept[0]});
        check(serial_out_oe_o, 1'b0);
    endtask
    initial begin
        rst_n_i = 1'b0;
        clk_en_i = 1'b1;
        supply_ok_i = 1'b1;
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        t_power();
        t_trial();
        t_store();
        t_low();
        t_unsel();
        close_out();
    end
endmodule // qnvdc_top_tb_top
`default_nettype wire
